/* logic/dmc2_pkg.sv */
// Constants and types for the second DPLL mode control register block.
// Assumes an APB master with 32-bit data and a single 50 MHz clock.
// Summary of operation
// - Holdover memory held reset while bit high
// - Holdover plus memory reset forces freerun
// - Tie correction runs while its reset low
// - Tie reset high: align to nearest edge
// - Mode 00 internal monitor, 01 external loss
// - Mode 10 forces primary, 11 secondary
// - B failure output enabled by its bit
// - A failure output enabled by its bit
// - Invert bit inverts both backplane references
// - Divider: pass, /193, /256, reserved
// - Source select picks local reference zero-three
package dmc2_pkg;
  localparam logic [11:0] DMC2_ADDR_MODE = 12'h02C;
  localparam logic [11:0] DMC2_ADDR_STAT = 12'h030;
  localparam logic [11:0] DMC2_ADDR_MASK = 12'h034;
  localparam logic [15:0] DMC2_MODE_RESET = 16'h0000;
  localparam logic [15:0] DMC2_MODE_WMASK = 16'h0FFB;
  localparam int DMC2_B_HOLDOVER_MEM_RESET = 11;
  localparam int DMC2_B_TRST = 10;
  localparam int DMC2_B_FDM = 8;
  localparam int DMC2_B_BEN = 7;
  localparam int DMC2_B_AEN = 6;
  localparam int DMC2_B_INV = 5;
  localparam int DMC2_B_DIV = 3;
  localparam int DMC2_B_SRC = 0;
  localparam int DMC2_DIV_193 = 193;
  localparam int DMC2_DIV_256 = 256;
  localparam int DMC2_NEV = 3;
  localparam int DMC2_EV_FREERUN = 0;
  localparam int DMC2_EV_FAIL_A = 1;
  localparam int DMC2_EV_FAIL_B = 2;
  typedef enum logic [1:0] {
    DMC2_FD_AUTO = 2'h0,
    DMC2_FD_EXT = 2'h1,
    DMC2_FD_PRI = 2'h2,
    DMC2_FD_SEC = 2'h3
  } dmc2_fdm_t;
  typedef enum logic [2:0] {
    DMC2_ST_LOCK = 3'h1,
    DMC2_ST_HOLD = 3'h2,
    DMC2_ST_FREE = 3'h4
  } dmc2_state_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dmc2_apb_req_t;
  typedef struct packed {
    logic [3:0] local_ref;
    logic backplane_ref_one;
    logic backplane_ref_two;
    logic primary_loss_in;
    logic secondary_loss_in;
    logic mon_pri_fail;
    logic mon_sec_fail;
  } dmc2_refs_t;
endpackage

/* logic/dmc2_ctrl.sv */
// Mode control register two with failure selection and network reference.
// Assumes refs are synchronous to clk and slow against it (edges seen).
`timescale 1ns/1ps
module dmc2_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire dmc2_pkg::dmc2_apb_req_t apb,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire dmc2_pkg::dmc2_refs_t refs,
  output logic backplane_ref_one_dpll,
  output logic backplane_ref_two_dpll,
  output logic use_secondary,
  output logic fail_out_a,
  output logic fail_out_b,
  output logic holdover_mem_rst,
  output logic tie_correction_rst,
  output logic align_nearest_edge,
  output logic in_freerun,
  output logic network_ref_out,
  output logic irq
);
  import dmc2_pkg::*;

  logic [15:0] mode;
  logic [DMC2_NEV-1:0] stat;
  logic [DMC2_NEV-1:0] mask;
  logic [DMC2_NEV-1:0] ev;
  dmc2_state_t st;
  dmc2_state_t next_st;
  logic [7:0] div_cnt;
  logic sel_ref;
  logic sel_ref_d;
  logic pri_fail;
  logic sec_fail;
  logic wr;
  logic rd;

  // ****************************************************
  // APB slave
  // ****************************************************
  // Write lands on the edge where the master sees pready high
  assign wr = apb.psel & apb.penable & apb.pwrite & pready;
  assign rd = apb.psel & ~apb.penable & ~apb.pwrite;

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb.psel & apb.penable & ~pready;
      pslverr <= apb.psel & apb.penable & ~pready &
        (apb.paddr != DMC2_ADDR_MODE) & (apb.paddr != DMC2_ADDR_STAT) &
        (apb.paddr != DMC2_ADDR_MASK);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      case (apb.paddr)
        DMC2_ADDR_MODE: prdata <= {16'h0000, mode};
        DMC2_ADDR_STAT: prdata <= {29'h0000_0000, stat};
        DMC2_ADDR_MASK: prdata <= {29'h0000_0000, mask};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Zero bits kept zero
  // Reserved bits are forced low so a careless write cannot alter them.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode <= DMC2_MODE_RESET;
    end else if (wr && apb.paddr == DMC2_ADDR_MODE) begin
      mode <= apb.pwdata[15:0] & DMC2_MODE_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mask <= '0;
    end else if (wr && apb.paddr == DMC2_ADDR_MASK) begin
      mask <= apb.pwdata[DMC2_NEV-1:0];
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stat <= '0;
    end else if (wr && apb.paddr == DMC2_ADDR_STAT) begin
      stat <= (stat & ~apb.pwdata[DMC2_NEV-1:0]) | ev;
    end else begin
      stat <= stat | ev;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat & mask);
    end
  end

  // ****************************************************
  // Failure detection
  // ****************************************************
  // Failure source selection
  always_comb begin
    pri_fail = 1'b0;
    sec_fail = 1'b0;
    case (dmc2_fdm_t'(mode[DMC2_B_FDM +: 2]))
      DMC2_FD_AUTO: begin
        pri_fail = refs.mon_pri_fail;
        sec_fail = refs.mon_sec_fail;
      end
      DMC2_FD_EXT: begin
        pri_fail = refs.primary_loss_in;
        sec_fail = refs.secondary_loss_in;
      end
      default: begin
        pri_fail = 1'b0;
        sec_fail = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      use_secondary <= 1'b0;
    end else begin
      case (dmc2_fdm_t'(mode[DMC2_B_FDM +: 2]))
        DMC2_FD_PRI: use_secondary <= 1'b0;
        DMC2_FD_SEC: use_secondary <= 1'b1;
        default: use_secondary <= pri_fail & ~sec_fail;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fail_out_a <= 1'b0;
      fail_out_b <= 1'b0;
    end else begin
      fail_out_a <= mode[DMC2_B_AEN] & pri_fail;
      fail_out_b <= mode[DMC2_B_BEN] & sec_fail;
    end
  end

  // ****************************************************
  // Holdover and freerun
  // ****************************************************
  always_comb begin
    next_st = st;
    case (st)
      DMC2_ST_LOCK: if (pri_fail & sec_fail) next_st = DMC2_ST_HOLD;
      DMC2_ST_HOLD: begin
        if (mode[DMC2_B_HOLDOVER_MEM_RESET]) next_st = DMC2_ST_FREE;
        else if (~(pri_fail & sec_fail)) next_st = DMC2_ST_LOCK;
      end
      DMC2_ST_FREE: if (~(pri_fail & sec_fail)) next_st = DMC2_ST_LOCK;
      default: next_st = DMC2_ST_LOCK;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= DMC2_ST_LOCK;
    end else begin
      st <= next_st;
    end
  end

  assign ev[DMC2_EV_FREERUN] = (st == DMC2_ST_HOLD) &&
    (next_st == DMC2_ST_FREE);
  assign ev[DMC2_EV_FAIL_A] = mode[DMC2_B_AEN] & pri_fail & ~fail_out_a;
  assign ev[DMC2_EV_FAIL_B] = mode[DMC2_B_BEN] & sec_fail & ~fail_out_b;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      holdover_mem_rst <= 1'b0;
      tie_correction_rst <= 1'b0;
      align_nearest_edge <= 1'b0;
      in_freerun <= 1'b0;
    end else begin
      holdover_mem_rst <= mode[DMC2_B_HOLDOVER_MEM_RESET];
      tie_correction_rst <= mode[DMC2_B_TRST];
      align_nearest_edge <= mode[DMC2_B_TRST];
      in_freerun <= (next_st == DMC2_ST_FREE);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      backplane_ref_one_dpll <= 1'b0;
      backplane_ref_two_dpll <= 1'b0;
    end else begin
      backplane_ref_one_dpll <= refs.backplane_ref_one ^ mode[DMC2_B_INV];
      backplane_ref_two_dpll <= refs.backplane_ref_two ^ mode[DMC2_B_INV];
    end
  end

  // ****************************************************
  // Network reference output
  // ****************************************************
  // Local source select
  assign sel_ref = refs.local_ref[mode[DMC2_B_SRC +: 2]];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sel_ref_d <= 1'b0;
    end else begin
      sel_ref_d <= sel_ref;
    end
  end

  // Divide by 193 or 256
  // Counter steps on rising edges of the chosen reference; output is
  // high for the first half of each divided period.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      div_cnt <= 8'h00;
    end else if (mode[DMC2_B_DIV +: 2] == 2'h1 &&
        div_cnt > 8'(DMC2_DIV_193 - 1)) begin
      // A count above the 193 period would otherwise run on to 255
      div_cnt <= 8'h00;
    end else if (sel_ref & ~sel_ref_d) begin
      if (mode[DMC2_B_DIV +: 2] == 2'h1 &&
          div_cnt == 8'(DMC2_DIV_193 - 1)) begin
        div_cnt <= 8'h00;
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      network_ref_out <= 1'b0;
    end else begin
      case (mode[DMC2_B_DIV +: 2])
        2'h0: network_ref_out <= sel_ref;
        2'h1: network_ref_out <= (div_cnt < 8'(DMC2_DIV_193 / 2));
        2'h2: network_ref_out <= (div_cnt < 8'(DMC2_DIV_256 / 2));
        default: network_ref_out <= 1'b0;
      endcase
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  AST_RSV_ZERO:
    assert property (@(posedge clk) disable iff (!reset_n)
      mode[15:12] == 4'h0 && mode[2] == 1'b0)
    else $error("reserved mode bits not zero");
  AST_HOLDOVER_MEM_RESET:
    assert property (@(posedge clk) disable iff (!reset_n)
      $past(reset_n) |-> holdover_mem_rst == $past(mode[DMC2_B_HOLDOVER_MEM_RESET]))
    else $error("holdover reset does not follow bit");
  AST_FREERUN:
    assert property (@(posedge clk) disable iff (!reset_n)
      (st == DMC2_ST_HOLD && mode[DMC2_B_HOLDOVER_MEM_RESET]) |=> st == DMC2_ST_FREE)
    else $error("holdover reset did not force freerun");
  AST_TIE:
    assert property (@(posedge clk) disable iff (!reset_n)
      mode[DMC2_B_TRST] |=> tie_correction_rst && align_nearest_edge)
    else $error("tie reset not applied");
  AST_FORCE:
    assert property (@(posedge clk) disable iff (!reset_n)
      mode[9] |=> use_secondary == $past(mode[8]))
    else $error("forced reference wrong");
  AST_FAIL_A:
    assert property (@(posedge clk) disable iff (!reset_n)
      !mode[DMC2_B_AEN] |=> !fail_out_a)
    else $error("disabled fail a active");
  AST_FAIL_B:
    assert property (@(posedge clk) disable iff (!reset_n)
      !mode[DMC2_B_BEN] |=> !fail_out_b)
    else $error("disabled fail b active");
  AST_INV:
    assert property (@(posedge clk) disable iff (!reset_n)
      $past(reset_n) |-> backplane_ref_one_dpll ==
        ($past(refs.backplane_ref_one) ^ $past(mode[DMC2_B_INV])))
    else $error("backplane inversion wrong");
  AST_DIV193:
    assert property (@(posedge clk) disable iff (!reset_n)
      mode[DMC2_B_DIV +: 2] == 2'h1 |=> div_cnt <= 8'(DMC2_DIV_193 - 1))
    else $error("divide by 193 overran");
  AST_EXT_SRC:
    assert property (@(posedge clk) disable iff (!reset_n)
      mode[DMC2_B_FDM +: 2] == 2'h1 |=> use_secondary ==
        ($past(refs.primary_loss_in) & ~$past(refs.secondary_loss_in)))
    else $error("external loss inputs not used");
  AST_FAIL_A_ON:
    assert property (@(posedge clk) disable iff (!reset_n)
      (mode[DMC2_B_AEN] && mode[DMC2_B_FDM +: 2] == 2'h1) |=>
        fail_out_a == $past(refs.primary_loss_in))
    else $error("enabled fail a does not report");
  AST_SRC:
    assert property (@(posedge clk) disable iff (!reset_n)
      mode[DMC2_B_DIV +: 2] == 2'h0 |=> network_ref_out == $past(sel_ref))
    else $error("network reference not the selected source");
  COV_DIV193: cover property (@(posedge clk)
    mode[DMC2_B_DIV +: 2] == 2'h1 && div_cnt == 8'(DMC2_DIV_193 - 1));
  COV_FREERUN: cover property (@(posedge clk) ev[DMC2_EV_FREERUN]);
  COV_IRQ: cover property (@(posedge clk) irq);
  COV_EXT: cover property (@(posedge clk) mode[9:8] == 2'h1 && fail_out_b);
endmodule

/* verif/dmc2_refs_model.sv */
// Far-side model: local references, backplane references and loss flags.
// Assumes the bench clock; failure flags come from the bench.
`timescale 1ns/1ps
module dmc2_refs_model (
  input wire logic clk,
  input wire logic [3:0] fail,
  output dmc2_pkg::dmc2_refs_t refs
);
  import dmc2_pkg::*;
  logic [4:0] cnt = 5'h00;
  always @(posedge clk) begin
    cnt <= cnt + 5'h01;
  end
  // Each local reference runs at its own rate so a wrong pick shows
  always_comb begin
    refs.local_ref = cnt[4:1];
    refs.backplane_ref_one = cnt[1];
    refs.backplane_ref_two = cnt[2];
    {refs.mon_pri_fail, refs.mon_sec_fail} = fail[3:2];
    {refs.primary_loss_in, refs.secondary_loss_in} = fail[1:0];
  end
endmodule

/* verif/dmc2_ctrl_tb.sv */
// Self-checking bench for the second mode control register block.
// Assumes the reference model file is compiled before it.
`timescale 1ns/1ps
module dmc2_ctrl_tb;
  import dmc2_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  dmc2_apb_req_t apb = '0;
  logic [3:0] fail = 4'h0;
  dmc2_refs_t refs, prv;
  logic pready, pslverr, bp1, bp2, use_sec, fa, fb, holdover_mem_reset, trst, algn;
  logic frun, nref, irq;
  logic [31:0] prdata, rd;
  logic er;
  int fails = 0;
  int checked = 0;
  int mm, n;
  // Flags, fail mode, expected secondary choice; revertive assumed
  logic [7:0] mm_tab [6] = '{8'h81, 8'h20, 8'h25, 8'h84, 8'h38, 8'h0D};
  always #10 clk = ~clk;
  always @(posedge clk) prv <= refs;
  dmc2_refs_model u_dmc2_refs_model (.clk(clk), .fail(fail), .refs(refs));
  dmc2_ctrl u_dmc2_ctrl (.clk(clk), .reset_n(reset_n), .apb(apb),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .refs(refs),
    .backplane_ref_one_dpll(bp1), .backplane_ref_two_dpll(bp2),
    .use_secondary(use_sec), .fail_out_a(fa), .fail_out_b(fb),
    .holdover_mem_rst(holdover_mem_reset), .tie_correction_rst(trst),
    .align_nearest_edge(algn), .in_freerun(frun),
    .network_ref_out(nref), .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Setup, then access held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int k;
    @(posedge clk);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) fails++;
    rd = prdata;
    er = pslverr;
    apb <= '0;
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h1180));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    xfer(1'b0, DMC2_ADDR_MODE, 32'h0);
    chk(rd, {16'h0, DMC2_MODE_RESET});
    xfer(1'b0, 12'h040, 32'h0);
    chk({er, rd[0]}, 32'h2);
    for (int i = 0; i < 4; i++) begin
      // Master mode only, so tie reset may be written low
      // Software keeps the zero bits zero
      mm = $urandom & 32'h0FFB;
      xfer(1'b1, DMC2_ADDR_MODE, mm);
      xfer(1'b1, 12'h040, 32'hFFFF);
      xfer(1'b0, DMC2_ADDR_MODE, 32'h0);
      chk(rd, mm & 32'h0FFB);
      settle();
      chk({holdover_mem_reset, trst, algn}, {mm[11], mm[10], mm[10]});
      chk({bp1, bp2}, {prv.backplane_ref_one ^ mm[5],
                       prv.backplane_ref_two ^ mm[5]});
    end
    $display("test register done");
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, DMC2_ADDR_MODE, s);
      settle();
      repeat (8) begin
        @(posedge clk);
        chk(nref, prv.local_ref[s]);
      end
    end
    xfer(1'b1, DMC2_ADDR_MODE, 32'h0018);
    settle();
    repeat (8) begin
      @(posedge clk);
      chk(nref, 32'h0);
    end
    for (int d = 1; d < 3; d++) begin
      xfer(1'b1, DMC2_ADDR_MODE, d << 3);
      repeat (1100) @(posedge clk);
      n = 0;
      repeat ((d == 1 ? DMC2_DIV_193 : DMC2_DIV_256) * 4) begin
        @(posedge clk);
        if (nref === 1'b1) n++;
      end
      chk(n, d == 1 ? 384 : 512);
    end
    $display("test netref done");
    foreach (mm_tab[j]) begin
      fail <= mm_tab[j][7:4];
      xfer(1'b1, DMC2_ADDR_MODE, {mm_tab[j][3:2], 8'h0});
      settle();
      chk(use_sec, mm_tab[j][0]);
      fail <= 4'h0;
      xfer(1'b1, DMC2_ADDR_MODE, 32'h0);
      settle();
    end
    for (int e = 0; e < 4; e++) begin
      fail <= 4'h3;
      xfer(1'b1, DMC2_ADDR_MODE, 32'h0100 | (e << 6));
      settle();
      chk({fb, fa}, e);
      fail <= 4'h0;
      xfer(1'b1, DMC2_ADDR_MODE, 32'h0);
      settle();
    end
    $display("test failure done");
    xfer(1'b1, DMC2_ADDR_STAT, 32'h7);
    xfer(1'b1, DMC2_ADDR_MASK, 32'h1);
    fail <= 4'hC;
    settle();
    chk(frun, 32'h0);
    xfer(1'b1, DMC2_ADDR_MODE, 32'h0800);
    settle();
    chk({frun, irq}, 32'h3);
    xfer(1'b0, DMC2_ADDR_STAT, 32'h0);
    chk(rd, 32'h1);
    xfer(1'b1, DMC2_ADDR_MASK, 32'h0);
    settle();
    chk(irq, 32'h0);
    fail <= 4'h0;
    xfer(1'b1, DMC2_ADDR_MODE, 32'h0);
    xfer(1'b1, DMC2_ADDR_MASK, 32'h1);
    xfer(1'b1, DMC2_ADDR_STAT, 32'h1);
    settle();
    chk({frun, irq}, 32'h0);
    $display("test freerun done");
    print_verdict();
  end
endmodule
